// *** common/supervisor_pkg.sv ***
// Constants for the supply supervisor with watchdog and reset stretch.
// Assumes a single 10 MHz clock; analog comparisons arrive as digital flags.
package supervisor_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int  CLK_FREQ_HZ                 = 10_000_000;
    localparam int  CLK_PERIOD_NS               = 100;
    // Reset stretch options in microseconds (1.4 ms, 28 ms, 200 ms, 1600 ms)
    localparam longint STRETCH_OPT_A_US         = 1400;
    localparam longint STRETCH_OPT_B_US         = 28000;
    localparam longint STRETCH_OPT_C_US         = 200000;
    localparam longint STRETCH_OPT_D_US         = 1600000;
    localparam longint RESET_STRETCH_TIME_US    = STRETCH_OPT_C_US;
    // Least time: round up
    localparam longint RESET_STRETCH_CYCLES     =
        (RESET_STRETCH_TIME_US * CLK_FREQ_HZ + 64'd999999) / 64'd1000000;
    // Watchdog timeout is customised per part; plain default
    localparam longint WATCHDOG_TIMEOUT_TIME_US = 1600000;
    // Longest time: round down
    localparam longint WATCHDOG_TIMEOUT_CYCLES  =
        (WATCHDOG_TIMEOUT_TIME_US * CLK_FREQ_HZ) / 64'd1000000;
    localparam int  COUNT_WIDTH                 = 32;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RESET_ACTIVE_N             = 1'b0;
    localparam logic WARN_INACTIVE_N            = 1'b1;
    // Synchronisers start as supply low and warning low: {kick, manual, warn, supply}
    localparam logic [3:0] SYNC_RESET_FLAGS     = 4'h3;
endpackage : supervisor_pkg

// *** common/kick_if.sv ***
// Carries the watchdog kick edge and expiry between supervisor modules.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface kick_if;
    logic kick_edge;   // Edge seen on the synchronised kick input
    logic hold_clear;  // Reset asserted: watchdog count held cleared
    logic expired;     // One-cycle pulse on timeout
    modport timer (input kick_edge, input hold_clear, output expired);
    modport owner (output kick_edge, output hold_clear, input expired);
endinterface : kick_if
`default_nettype wire

// *** hdl/watchdog_timer.sv ***
// Watchdog counter: restarts on every kick edge, pulses on timeout.
// Assumes kick edges already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer
    import supervisor_pkg::*;
#(
    parameter longint TIMEOUT_CYCLES = WATCHDOG_TIMEOUT_CYCLES
) (
    input  wire logic clk,    // 10 MHz clock
    input  wire logic rst_n,  // Async reset, active low
    kick_if.timer     kick    // Kick edge, clear and expiry
);
    import supervisor_pkg::*;
    localparam logic [COUNT_WIDTH-1:0] LAST = COUNT_WIDTH'(TIMEOUT_CYCLES - 1);

    logic [COUNT_WIDTH-1:0] count_reg;
    logic [COUNT_WIDTH-1:0] count_next;
    logic                   expired_reg;
    wire                    at_last = (count_reg == LAST);

    // Restart on edge, hold cleared in reset
    assign count_next = (kick.kick_edge || kick.hold_clear || at_last) ? '0
                                                                       : count_reg + 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg   <= '0;
            expired_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            // No edge for the full period ends in reset
            expired_reg <= at_last && !kick.kick_edge && !kick.hold_clear;
        end
    end
    assign kick.expired = expired_reg;

    count_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        kick.hold_clear |=> count_reg == '0)
        else $error("Watchdog count not cleared during reset");
endmodule : watchdog_timer
`default_nettype wire

// *** hdl/supply_supervisor_watchdog_reset.sv ***
// Supply supervisor: reset generation, reset stretch, low-line warning, watchdog.
// Assumes supply, low-line and manual reset arrive as asynchronous digital flags.
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_reset
    import supervisor_pkg::*;
#(
    parameter longint STRETCH_CYCLES = RESET_STRETCH_CYCLES,
    parameter longint WD_CYCLES      = WATCHDOG_TIMEOUT_CYCLES
) (
    input  wire logic clk,               // 10 MHz clock
    input  wire logic rst_n,             // Async reset, active low
    input  wire logic supply_low,        // Supply below reset threshold
    input  wire logic supply_warn_low,   // Supply below low-line threshold
    input  wire logic manual_reset_in_n, // Manual reset, active low
    input  wire logic watchdog_kick_in,  // Watchdog kick from processor
    output logic      reset_out_n,       // Reset, active low
    output logic      reset_out,         // Reset, active high
    output logic      low_line_warn_n    // Early power-fail warning, active low
);
    import supervisor_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic       kick_prev_reg;

    // Two stages per flag; only the second stage is read by any logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Assume worst case until inputs are seen
            sync1_reg     <= SYNC_RESET_FLAGS;
            sync2_reg     <= SYNC_RESET_FLAGS;
            kick_prev_reg <= 1'b0;
        end else begin
            sync1_reg     <= {watchdog_kick_in, !manual_reset_in_n, supply_warn_low, supply_low};
            sync2_reg     <= sync1_reg;
            kick_prev_reg <= sync2_reg[3];
        end
    end

    wire supply_low_s = sync2_reg[0];
    wire warn_low_s   = sync2_reg[1];
    wire manual_s     = sync2_reg[2];
    wire kick_s       = sync2_reg[3];
    wire hold_cond    = supply_low_s || manual_s;

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // Either direction counts as activity, so a line stuck at one level still expires
    // Limitation: two toggles within one clock can merge in the synchroniser
    kick_if kick_bus ();
    assign kick_bus.kick_edge  = kick_s ^ kick_prev_reg;
    assign kick_bus.hold_clear = !reset_out_n;

    watchdog_timer #(
        .TIMEOUT_CYCLES (WD_CYCLES)
    ) u_watchdog (
        .clk   (clk),
        .rst_n (rst_n),
        .kick  (kick_bus.timer)
    );

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    // Reset output is registered from the next state, so it never glitches
    typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} seq_type;

    localparam logic [COUNT_WIDTH-1:0] STRETCH_LAST = COUNT_WIDTH'(STRETCH_CYCLES - 1);

    seq_type                state_reg;
    seq_type                state_next;
    logic [COUNT_WIDTH-1:0] stretch_reg;
    logic [COUNT_WIDTH-1:0] stretch_next;
    logic                   reset_n_reg;
    logic                   warn_n_reg;
    wire                    stretch_done = (stretch_reg == STRETCH_LAST);

    always_comb begin
        state_next   = state_reg;
        stretch_next = '0;
        unique case (state_reg)
            ST_HOLD: begin
                if (!hold_cond) state_next = ST_STRETCH;
            end
            ST_STRETCH: begin
                // A condition returning mid-stretch goes back to hold and restarts the count
                stretch_next = stretch_reg + 1'b1;
                if (hold_cond) begin
                    state_next   = ST_HOLD;
                    stretch_next = '0;
                end else if (stretch_done) begin
                    state_next   = ST_RUN;
                    stretch_next = '0;
                end
            end
            ST_RUN: begin
                if (hold_cond) state_next = ST_HOLD;
                else if (kick_bus.expired) state_next = ST_STRETCH;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= ST_HOLD;
            stretch_reg <= '0;
            reset_n_reg <= RESET_ACTIVE_N;
            warn_n_reg  <= WARN_INACTIVE_N;
        end else begin
            state_reg   <= state_next;
            stretch_reg <= stretch_next;
            reset_n_reg <= (state_next == ST_RUN);
            // Warning level is the threshold plus the 2% margin, compared outside
            warn_n_reg  <= !(warn_low_s || supply_low_s);
        end
    end

    // Both levels come from one flop: they cannot disagree, at the cost of an inverter delay
    assign reset_out_n     = reset_n_reg;
    assign reset_out       = !reset_n_reg;
    assign low_line_warn_n = warn_n_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    hold_keeps_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        hold_cond |=> !reset_out_n)
        else $error("Reset released while supply low or manual reset held");

    stretch_after_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(hold_cond) |-> !reset_out_n [*8])
        else $error("Reset released too soon after recovery");

    expiry_asserts_a: assert property (@(posedge clk) disable iff (!rst_n)
        (kick_bus.expired && reset_out_n) |=> !reset_out_n)
        else $error("Watchdog expiry did not assert reset");

    stretch_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(reset_out_n) |-> $past(stretch_reg) == STRETCH_LAST)
        else $error("Reset released before full stretch");

    complement_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        reset_out == !reset_out_n)
        else $error("Active-high reset not the complement");

    warn_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
        warn_low_s |=> !low_line_warn_n)
        else $error("Low-line warning not asserted");

    supply_low_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        supply_low_s |=> state_reg == ST_HOLD)
        else $error("Sequencer not holding while supply low");

    kick_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        kick_bus.kick_edge |=> !kick_bus.expired)
        else $error("Expiry right after a kick");

    // ------------------------------------------------------------
    // Checks: sequencer detail, watchdog muting and low-line warning
    // ------------------------------------------------------------
    // Each transition of the sequencer is tied to the condition that allows it
    hold_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_HOLD && !hold_cond) |=> state_reg == ST_STRETCH)
        else $error("Stretch did not start after recovery");

    hold_zero_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_HOLD |-> stretch_reg == '0)
        else $error("Stretch count not cleared while holding");

    stretch_counts_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_STRETCH && !hold_cond && !stretch_done) |=>
            (state_reg == ST_STRETCH && stretch_reg == $past(stretch_reg) + 1'b1))
        else $error("Stretch count skipped or stopped early");

    stretch_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_STRETCH |-> !reset_out_n)
        else $error("Reset released during stretch");

    release_when_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(reset_out_n) |-> !$past(hold_cond))
        else $error("Reset released while a hold condition stood");

    manual_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
        manual_s |=> state_reg == ST_HOLD)
        else $error("Sequencer not holding while manual reset held");

    run_stays_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reset_out_n && !hold_cond && !kick_bus.expired) |=> reset_out_n)
        else $error("Reset asserted with no cause");

    expiry_restarts_a: assert property (@(posedge clk) disable iff (!rst_n)
        (kick_bus.expired && reset_out_n && !hold_cond) |=>
            (state_reg == ST_STRETCH && stretch_reg == '0))
        else $error("Expiry did not start a full stretch");

    reset_mutes_expiry_a: assert property (@(posedge clk) disable iff (!rst_n)
        !reset_out_n |=> !kick_bus.expired)
        else $error("Watchdog expired while reset asserted");

    warn_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!warn_low_s && !supply_low_s) |=> low_line_warn_n)
        else $error("Low-line warning stuck with supply good");

    supply_forces_warn_a: assert property (@(posedge clk) disable iff (!rst_n)
        supply_low_s |=> !low_line_warn_n)
        else $error("Low-line warning not asserted below reset level");
endmodule : supply_supervisor_watchdog_reset
`default_nettype wire

// *** dv/cpu_model.sv ***
// Processor model on the far side: drives the watchdog kick line.
// Assumes the bench clock; the kick line only changes after a falling edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
    parameter int KICK_PERIOD = 10
) (
    input  wire logic clk,       // Bench clock
    input  wire logic kick_en,   // Keep kicking while high
    output logic      kick_out   // Watchdog kick line, held when idle
);
    int unsigned gap;
    initial begin
        kick_out = 1'b0;
        gap      = 0;
    end
    // Toggle well inside the timeout; stopping is how expiry is provoked
    always @(negedge clk) begin
        gap = gap + 1;
        if (kick_en && gap >= KICK_PERIOD) begin
            kick_out <= ~kick_out;
            gap = 0;
        end
    end
endmodule : cpu_model
`default_nettype wire

// *** dv/tb_supply_supervisor_watchdog_reset.sv ***
// Self-checking bench for the supply supervisor with watchdog.
// Assumes short stretch and watchdog counts; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_supply_supervisor_watchdog_reset;
    import supervisor_pkg::*;
    localparam int S = 20;
    localparam int W = 50;
    typedef struct packed {
        logic sl; logic wl; logic mr_n; logic rst_n_exp; logic warn_n_exp;
    } row_type;
    // Supply low, warn low, manual reset, expected reset_n, expected warn_n
    row_type rows [6] = '{5'h07, 5'h0e, 5'h1c, 5'h14, 5'h01, 5'h08};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_low = 1'b0;
    logic supply_warn_low = 1'b0;
    logic manual_reset_in_n = 1'b1;
    logic kick_en = 1'b1;
    logic watchdog_kick_in;
    logic reset_out_n;
    logic reset_out;
    logic low_line_warn_n;
    int n_mismatch = 0;
    int comparisons = 0;
    int n;
    always #50 clk = ~clk;
    supply_supervisor_watchdog_reset #(.STRETCH_CYCLES(S), .WD_CYCLES(W)) i_dut (
        .clk(clk), .rst_n(rst_n), .supply_low(supply_low),
        .supply_warn_low(supply_warn_low), .manual_reset_in_n(manual_reset_in_n),
        .watchdog_kick_in(watchdog_kick_in), .reset_out_n(reset_out_n),
        .reset_out(reset_out), .low_line_warn_n(low_line_warn_n));
    cpu_model #(.KICK_PERIOD(10)) i_cpu (
        .clk(clk), .kick_en(kick_en), .kick_out(watchdog_kick_in));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    // Cycles until reset releases; bounded so a stuck reset cannot hang
    task automatic measure(output int cnt);
        cnt = 0;
        while (reset_out_n !== 1'b1 && cnt < 4 * W) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 4 * W) begin
            n_mismatch++;
            conclude();
        end
    endtask : measure
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        check("rst reset_out_n", reset_out_n, 1'b0);
        check("rst reset_out", reset_out, 1'b1);
        check("rst warn_n", low_line_warn_n, 1'b1);
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        measure(n);
        check("power-up stretch", n >= S, 1'b1);
        foreach (rows[i]) begin
            supply_low        = rows[i].sl;
            supply_warn_low   = rows[i].wl;
            manual_reset_in_n = rows[i].mr_n;
            repeat (5) @(negedge clk);
            check("reset_out_n", reset_out_n, rows[i].rst_n_exp);
            check("warn_n", low_line_warn_n, rows[i].warn_n_exp);
            check("complement", reset_out, ~reset_out_n);
            supply_low        = 1'b0;
            supply_warn_low   = 1'b0;
            manual_reset_in_n = 1'b1;
            measure(n);
            if (!rows[i].rst_n_exp) begin
                check("stretch", n >= S && n <= S + 6, 1'b1);
            end
        end
        // Condition returning mid-stretch must restart the full stretch
        supply_low = 1'b1;
        repeat (5) @(negedge clk);
        supply_low = 1'b0;
        repeat (10) @(negedge clk);
        supply_low = 1'b1;
        repeat (5) @(negedge clk);
        check("re-held", reset_out_n, 1'b0);
        supply_low = 1'b0;
        measure(n);
        check("restretch", n >= S, 1'b1);
        // Kicks stop: expiry from W-10 to W+5 cycles after kicking stops
        kick_en = 1'b0;
        n = 0;
        while (reset_out_n === 1'b1 && n < 4 * W) begin
            @(negedge clk);
            n++;
        end
        check("expiry time", n >= W - 10 && n <= W + 5, 1'b1);
        check("wd complement", reset_out, 1'b1);
        measure(n);
        check("wd pulse", n >= S && n <= S + 6, 1'b1);
        kick_en = 1'b1;
        repeat (3 * W) @(negedge clk);
        check("kicked", reset_out_n, 1'b1);
        // Reset in mid-run: reset values return, then a full stretch follows
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        check("mid rst reset_out_n", reset_out_n, 1'b0);
        check("mid rst reset_out", reset_out, 1'b1);
        check("mid rst warn_n", low_line_warn_n, 1'b1);
        rst_n = 1'b1;
        measure(n);
        check("mid rst stretch", n >= S && n <= S + 6, 1'b1);
        conclude();
    end
endmodule : tb_supply_supervisor_watchdog_reset
`default_nettype wire
